// [design/ess_store_sequencer.sv]
// EEPROM store sequencer: scratch-pad instruction list, register-map copy, AHB-Lite slave
//
// Register access over AHB-Lite is this design's own decision.
`timescale 1ns/1ps
module ess_store_sequencer (
  input  wire logic                           CLK,
  input  wire logic                           RST_N,
  input  wire logic                           HSEL,
  input  wire logic [31:0]                    HADDR,
  input  wire logic [1:0]                     HTRANS,
  input  wire logic                           HWRITE,
  input  wire logic [2:0]                     HSIZE,
  input  wire logic [31:0]                    HWDATA,
  input  wire logic                           HREADY,
  output logic      [31:0]                    HRDATA,
  output logic                                HREADYOUT,
  output logic                                HRESP,
  output logic                                RM_RD,
  output logic      [15:0]                    RM_ADDR,
  input  wire logic [7:0]                     RM_RDATA,
  output logic                                EE_VALID,
  output ess_pkg::ess_word_t                  EE_WORD,
  input  wire logic                           EE_READY
);
  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  logic [7:0]                     sp_r [ess_pkg::SP_DEPTH];
  ess_pkg::ess_state_t            st_r;
  logic [3:0]                     idx_r;
  logic [ess_pkg::EE_ADDR_W-1:0]  ptr_r;
  logic [7:0]                     cnt_r;
  logic [15:0]                    src_r;
  logic [7:0]                     dat_r;
  logic [7:0]                     sum_r;
  logic                           done_r;
  logic                           wr_pend_r;
  logic [11:0]                    wr_idx_r;
  logic                           head_valid_r;
  ess_pkg::ess_word_t             head_r;
  logic                           skid_valid_r;
  ess_pkg::ess_word_t             skid_r;

  // ------------------------------------------------------------
  // Bus decode
  // ------------------------------------------------------------
  wire logic        addr_ph  = HSEL & HREADY & (HTRANS == ess_pkg::HTRANS_NONSEQ);
  wire logic        hi_ok    = (HADDR[31:14] == ess_pkg::HADDR_HI_ZERO);
  wire logic [11:0] a_idx    = HADDR[13:2];
  wire logic [11:0] a_off    = a_idx - ess_pkg::IDX_SP_FIRST;
  wire logic        a_in_sp  = hi_ok & (a_idx >= ess_pkg::IDX_SP_FIRST) & (a_off <= 12'(ess_pkg::SP_LAST));
  wire logic [11:0] w_off    = wr_idx_r - ess_pkg::IDX_SP_FIRST;
  wire logic        w_in_sp  = (wr_idx_r >= ess_pkg::IDX_SP_FIRST) & (w_off <= 12'(ess_pkg::SP_LAST));
  wire logic        w_ctrl   = wr_pend_r & (wr_idx_r == ess_pkg::IDX_CTRL);
  wire logic        busy     = (st_r != ess_pkg::ST_IDLE);
  wire logic        start    = w_ctrl & HWDATA[ess_pkg::CTRL_START_BIT] & ~busy;
  wire logic        clr_done = w_ctrl & HWDATA[ess_pkg::CTRL_CLRDN_BIT];
  wire logic [31:0] stat_w   = {30'h0000_0000, done_r, busy};
  wire logic [31:0] rd_word  = a_in_sp ? {24'h00_0000, sp_r[a_off[3:0]]} :
                               (hi_ok & a_idx == ess_pkg::IDX_STATUS) ? stat_w :
                               (hi_ok & a_idx == ess_pkg::IDX_POINTER) ?
                                 {20'h0_0000, ptr_r} : 32'h0000_0000;

  // ------------------------------------------------------------
  // Sequencer push path
  // ------------------------------------------------------------
  wire logic [7:0]  sp_byte  = sp_r[idx_r];
  wire logic        idx_ok   = (idx_r <= ess_pkg::SP_LAST);
  wire logic        in_ready = ~skid_valid_r;
  wire logic        scr_st   = (st_r == ess_pkg::ST_FETCH) | (st_r == ess_pkg::ST_ADDR_HI) |
                               (st_r == ess_pkg::ST_ADDR_LO);
  wire logic        push_v   = (scr_st & idx_ok) | (st_r == ess_pkg::ST_PUSH) | (st_r == ess_pkg::ST_CSUM);
  wire logic [7:0]  csum     = 8'h00 - sum_r;
  wire logic [7:0]  push_d   = scr_st ? sp_byte : (st_r == ess_pkg::ST_PUSH) ? dat_r : csum;
  wire logic        acc      = push_v & in_ready;
  wire logic        is_data  = ~sp_byte[ess_pkg::INSTR_KIND_BIT];
  wire logic        is_end   = (sp_byte == ess_pkg::INSTR_END);
  wire logic        pop      = head_valid_r & EE_READY;
  wire logic        head_tk  = ~head_valid_r | EE_READY;
  ess_pkg::ess_word_t push_w;
  assign push_w = '{addr: ptr_r, data: push_d};

  // ------------------------------------------------------------
  // Scratch pad and bus slave
  // ------------------------------------------------------------
  // default list
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      sp_r[0]  <= ess_pkg::RST_COUNT;
      sp_r[1]  <= ess_pkg::RST_P23_START[15:8];
      sp_r[2]  <= ess_pkg::RST_P23_START[7:0];
      sp_r[3]  <= ess_pkg::RST_COUNT;
      sp_r[4]  <= ess_pkg::RST_P45_START[15:8];
      sp_r[5]  <= ess_pkg::RST_P45_START[7:0];
      sp_r[6]  <= ess_pkg::RST_COUNT;
      sp_r[7]  <= ess_pkg::RST_P67_START[15:8];
      sp_r[8]  <= ess_pkg::RST_P67_START[7:0];
      sp_r[9]  <= ess_pkg::INSTR_UPDATE;
      sp_r[10] <= ess_pkg::INSTR_END;
    end else if (wr_pend_r & w_in_sp) begin
      sp_r[w_off[3:0]] <= HWDATA[7:0];
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      wr_pend_r <= 1'b0;
      wr_idx_r  <= 12'h000;
      HRDATA    <= 32'h0000_0000;
      HREADYOUT <= 1'b0;
      HRESP     <= 1'b0;
    end else begin
      wr_pend_r <= addr_ph & HWRITE & hi_ok;
      wr_idx_r  <= a_idx;
      HRDATA    <= (addr_ph & ~HWRITE) ? rd_word : 32'h0000_0000;
      HREADYOUT <= 1'b1;
      HRESP     <= 1'b0;
    end
  end

  // Done is sticky; a completion in the clearing cycle wins
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      done_r <= 1'b0;
    end else if ((st_r == ess_pkg::ST_FETCH) & acc & is_end) begin
      done_r <= 1'b1;
    end else if (clr_done) begin
      done_r <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      st_r    <= ess_pkg::ST_IDLE;
      idx_r   <= 4'h0;
      ptr_r   <= '0;
      cnt_r   <= 8'h00;
      src_r   <= 16'h0000;
      dat_r   <= 8'h00;
      sum_r   <= 8'h00;
      RM_RD   <= 1'b0;
      RM_ADDR <= 16'h0000;
    end else begin
      RM_RD <= 1'b0;
      unique case (st_r)
        ess_pkg::ST_IDLE: begin
          if (start) begin
            idx_r <= 4'h0;
            ptr_r <= '0;
            st_r  <= ess_pkg::ST_FETCH;
          end
        end
        ess_pkg::ST_FETCH: begin
          if (!idx_ok) begin
            st_r <= ess_pkg::ST_IDLE;
          end else if (acc) begin
            idx_r <= idx_r + 4'h1;
            if (is_end) begin
              ptr_r <= '0;
              st_r  <= ess_pkg::ST_IDLE;
            end else if (is_data) begin
              cnt_r <= sp_byte;
              ptr_r <= ptr_r + 1'b1;
              st_r  <= ess_pkg::ST_ADDR_HI;
            end else begin
              ptr_r <= ptr_r + 1'b1;
            end
          end
        end
        ess_pkg::ST_ADDR_HI: begin
          if (!idx_ok) begin
            st_r <= ess_pkg::ST_IDLE;
          end else if (acc) begin
            src_r[15:8] <= sp_byte;
            idx_r       <= idx_r + 4'h1;
            ptr_r       <= ptr_r + 1'b1;
            st_r        <= ess_pkg::ST_ADDR_LO;
          end
        end
        ess_pkg::ST_ADDR_LO: begin
          if (!idx_ok) begin
            st_r <= ess_pkg::ST_IDLE;
          end else if (acc) begin
            src_r[7:0] <= sp_byte;
            idx_r      <= idx_r + 4'h1;
            ptr_r      <= ptr_r + 1'b1;
            sum_r      <= 8'h00;
            st_r       <= ess_pkg::ST_RD;
          end
        end
        ess_pkg::ST_RD: begin
          RM_RD   <= 1'b1;
          RM_ADDR <= src_r;
          st_r    <= ess_pkg::ST_WAIT;
        end
        ess_pkg::ST_WAIT: begin
          if (!RM_RD) begin
            dat_r <= RM_RDATA;
            st_r  <= ess_pkg::ST_PUSH;
          end
        end
        ess_pkg::ST_PUSH: begin
          if (acc) begin
            sum_r <= sum_r + dat_r;
            ptr_r <= ptr_r + 1'b1;
            src_r <= src_r + 16'h0001;
            cnt_r <= cnt_r - 8'h01;
            st_r  <= (cnt_r == 8'h00) ? ess_pkg::ST_CSUM : ess_pkg::ST_RD;
          end
        end
        ess_pkg::ST_CSUM: begin
          if (acc) begin
            ptr_r <= ptr_r + 1'b1;
            st_r  <= ess_pkg::ST_FETCH;
          end
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // Two-entry buffer toward the EEPROM
  // ------------------------------------------------------------
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      head_valid_r <= 1'b0;
      head_r       <= '0;
      skid_valid_r <= 1'b0;
      skid_r       <= '0;
    end else if (head_tk) begin
      if (skid_valid_r) begin
        head_r       <= skid_r;
        head_valid_r <= 1'b1;
        skid_valid_r <= 1'b0;
      end else begin
        head_r       <= push_w;
        head_valid_r <= acc;
      end
    end else if (acc) begin
      skid_r       <= push_w;
      skid_valid_r <= 1'b1;
    end
  end

  assign EE_VALID = head_valid_r;
  assign EE_WORD  = head_r;

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  logic seen_r;
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      seen_r <= 1'b0;
    end else begin
      seen_r <= 1'b1;
    end
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  a_data_count: assert property ((st_r == ess_pkg::ST_FETCH) && acc && is_data |=>
    (cnt_r == $past(sp_byte)) && (st_r == ess_pkg::ST_ADDR_HI)) else $error("data count not taken");
  a_start_addr: assert property ((st_r == ess_pkg::ST_ADDR_LO) && acc |=>
    (src_r == {$past(src_r[15:8]), $past(sp_byte)}) && (st_r == ess_pkg::ST_RD)) else $error("bad start address");
  a_instr_store: assert property ((st_r == ess_pkg::ST_FETCH) && acc && is_data |->
    (push_w.data == sp_byte) ##1 (ptr_r == $past(ptr_r) + 1'b1)) else $error("instruction not stored");
  a_addr_step: assert property ((st_r == ess_pkg::ST_ADDR_HI) && acc ##1 (st_r == ess_pkg::ST_ADDR_LO) && acc
    |=> ptr_r == $past(ptr_r, 2) + 2'd2) else $error("address bytes step wrong");
  a_copy_read: assert property ((st_r == ess_pkg::ST_RD) |=> RM_RD && (RM_ADDR == $past(src_r))
    ##2 (st_r == ess_pkg::ST_PUSH) && (dat_r == $past(RM_RDATA))) else $error("map read misplaced");
  a_update_step: assert property ((st_r == ess_pkg::ST_FETCH) && acc && (sp_byte == ess_pkg::INSTR_UPDATE)
    |=> (st_r == ess_pkg::ST_FETCH) && (ptr_r == $past(ptr_r) + 1'b1)) else $error("update step wrong");
  a_default_p23: assert property (!seen_r |-> (sp_r[0] == 8'h63) &&
    ({sp_r[1], sp_r[2]} == 16'h0680)) else $error("profile 2/3 default wrong");
  a_default_p45: assert property (!seen_r |-> (sp_r[3] == 8'h63) &&
    ({sp_r[4], sp_r[5]} == 16'h0700)) else $error("profile 4/5 default wrong");
  a_default_p67: assert property (!seen_r |-> (sp_r[6] == 8'h63) &&
    ({sp_r[7], sp_r[8]} == 16'h0780) && (sp_r[9] == 8'h80)) else $error("profile 6/7 default wrong");
  a_end_idle: assert property ((st_r == ess_pkg::ST_FETCH) && acc && is_end
    |=> (ptr_r == '0) && (st_r == ess_pkg::ST_IDLE) && done_r) else $error("end not handled");
  a_csum_zero: assert property ((st_r == ess_pkg::ST_CSUM) && acc |->
    (8'(sum_r + push_w.data) == 8'h00)) else $error("checksum does not cancel sum");

  c_full_buffer: cover property (skid_valid_r && head_valid_r && !EE_READY);
  c_block_done:  cover property ((st_r == ess_pkg::ST_CSUM) && acc);
  c_list_end:    cover property ((st_r == ess_pkg::ST_FETCH) && acc && is_end);
  c_skid_drain:  cover property (pop && skid_valid_r);
endmodule // ess_store_sequencer

// [design/ess_pkg.sv]
// Package for the EEPROM store sequencer: map, defaults, states and carriers
package ess_pkg;
  // ------------------------------------------------------------
  // Register indices (byte address = 4 * index)
  // ------------------------------------------------------------
  localparam logic [11:0] IDX_P23_COUNT   = 12'h0E25;
  localparam logic [11:0] IDX_P23_START_H = 12'h0E26;
  localparam logic [11:0] IDX_P23_START_L = 12'h0E27;
  localparam logic [11:0] IDX_P45_COUNT   = 12'h0E28;
  localparam logic [11:0] IDX_P45_START_H = 12'h0E29;
  localparam logic [11:0] IDX_P45_START_L = 12'h0E2A;
  localparam logic [11:0] IDX_P67_COUNT   = 12'h0E2B;
  localparam logic [11:0] IDX_P67_START_H = 12'h0E2C;
  localparam logic [11:0] IDX_P67_START_L = 12'h0E2D;
  localparam logic [11:0] IDX_UPDATE_STEP = 12'h0E2E;
  localparam logic [11:0] IDX_TAIL_STEP   = 12'h0E2F;
  localparam logic [11:0] IDX_CTRL        = 12'h0E40;
  localparam logic [11:0] IDX_STATUS      = 12'h0E41;
  localparam logic [11:0] IDX_POINTER     = 12'h0E42;
  localparam logic [11:0] IDX_SP_FIRST    = IDX_P23_COUNT;
  localparam int          SP_DEPTH        = 11;
  localparam logic [3:0]  SP_LAST         = 4'hA;
  // ------------------------------------------------------------
  // Reset values of the scratch pad, in list order
  // ------------------------------------------------------------
  localparam logic [7:0]  RST_COUNT       = 8'h63;
  localparam logic [15:0] RST_P23_START   = 16'h0680;
  localparam logic [15:0] RST_P45_START   = 16'h0700;
  localparam logic [15:0] RST_P67_START   = 16'h0780;
  localparam logic [7:0]  INSTR_UPDATE    = 8'h80;
  localparam logic [7:0]  INSTR_END       = 8'hFF;
  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int          CTRL_START_BIT  = 0;
  localparam int          CTRL_CLRDN_BIT  = 1;
  localparam int          STAT_BUSY_BIT   = 0;
  localparam int          STAT_DONE_BIT   = 1;
  localparam int          INSTR_KIND_BIT  = 7;
  localparam int          EE_ADDR_W       = 12;
  localparam logic [1:0]  HTRANS_NONSEQ   = 2'h2;
  localparam logic [31:14] HADDR_HI_ZERO  = 18'h0_0000;

  typedef enum logic [2:0] {
    ST_IDLE, ST_FETCH, ST_ADDR_HI, ST_ADDR_LO, ST_RD, ST_WAIT, ST_PUSH, ST_CSUM
  } ess_state_t;

  typedef struct packed {
    logic [EE_ADDR_W-1:0] addr;
    logic [7:0]           data;
  } ess_word_t;
endpackage

// [dv/ess_ee_model.sv]
// Partner model: register-map read port and EEPROM storage array
`timescale 1ns/1ps
module ess_ee_model (
  input  wire logic               CLK,
  input  wire logic               RST_N,
  input  wire logic               SLOW,
  input  wire logic               RM_RD,
  input  wire logic [15:0]        RM_ADDR,
  output logic      [7:0]         RM_RDATA,
  input  wire logic               EE_VALID,
  input  wire ess_pkg::ess_word_t EE_WORD,
  output logic                    EE_READY
);
  ess_pkg::ess_word_t log_q[$];
  logic [1:0]         gap_r;

  // Map content is a mix of both address bytes so a wrong source shows
  function automatic logic [7:0] rm_val(input logic [15:0] a);
    return a[7:0] ^ {a[10:8], a[15:11]} ^ 8'h5A;
  endfunction

  // ------------------------------------------------------------
  // Map data one cycle after the strobe, stored words kept in order
  // ------------------------------------------------------------
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      RM_RDATA <= 8'h00;
      EE_READY <= 1'b0;
      gap_r    <= 2'h0;
    end else begin
      gap_r    <= gap_r + 2'h1;
      // map bytes only valid just after a read
      RM_RDATA <= RM_RD ? rm_val(RM_ADDR) : ~RM_RDATA;
      EE_READY <= !SLOW || (gap_r == 2'h3);
      if (EE_VALID && EE_READY)
        log_q.push_back(EE_WORD);
    end
  end
endmodule // ess_ee_model

// [dv/tb.sv]
// Testbench for the EEPROM store sequencer
`timescale 1ns/1ps
module tb;
  logic                CLK;
  logic                RST_N;
  logic                HSEL;
  logic [31:0]         HADDR;
  logic [1:0]          HTRANS;
  logic                HWRITE;
  logic [2:0]          HSIZE;
  logic [31:0]         HWDATA;
  logic                SLOW;
  wire  [31:0]         HRDATA;
  wire                 HREADYOUT;
  wire                 HRESP;
  wire                 RM_RD;
  wire  [15:0]         RM_ADDR;
  wire  [7:0]          RM_RDATA;
  wire                 EE_VALID;
  ess_pkg::ess_word_t  EE_WORD;
  wire                 EE_READY;
  int                  err_total;
  int                  tests_run;
  int                  cyc_r;
  logic [7:0]          sp [11] = '{8'h63, 8'h06, 8'h80, 8'h63, 8'h07, 8'h00, 8'h63, 8'h07, 8'h80, 8'h80, 8'hFF};
  logic [7:0]          exp_q[$];

  ess_store_sequencer uut (.CLK(CLK), .RST_N(RST_N), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
    .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADYOUT), .HRDATA(HRDATA),
    .HREADYOUT(HREADYOUT), .HRESP(HRESP), .RM_RD(RM_RD), .RM_ADDR(RM_ADDR), .RM_RDATA(RM_RDATA),
    .EE_VALID(EE_VALID), .EE_WORD(EE_WORD), .EE_READY(EE_READY));
  ess_ee_model ee (.CLK(CLK), .RST_N(RST_N), .SLOW(SLOW), .RM_RD(RM_RD), .RM_ADDR(RM_ADDR),
    .RM_RDATA(RM_RDATA), .EE_VALID(EE_VALID), .EE_WORD(EE_WORD), .EE_READY(EE_READY));

  initial begin
    CLK = 1'b0;
    forever #20 CLK = ~CLK;
  end

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  always @(posedge CLK) begin
    cyc_r++;
    if (cyc_r == 40000) begin
      err_total++;
      final_report();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] expv);
    tests_run++;
    if (seen !== expv) begin
      err_total++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, expv);
    end
  endtask

  // Single AHB-Lite transfer, zero or more wait states
  task automatic bus(input logic wr, input logic [11:0] idx, input logic [31:0] wd, output logic [31:0] rd);
    HSEL   <= 1'b1;
    HTRANS <= ess_pkg::HTRANS_NONSEQ;
    HADDR  <= {18'h0_0000, idx, 2'h0};
    HWRITE <= wr;
    do @(posedge CLK); while (HREADYOUT !== 1'b1);
    HSEL   <= 1'b0;
    HTRANS <= 2'h0;
    HWDATA <= wd;
    do @(posedge CLK); while (HREADYOUT !== 1'b1);
    rd = HRDATA;
  endtask

  // Expected store stream worked out from the scratch-pad list
  function automatic void expand();
    int         i;
    logic [7:0] b;
    logic [7:0] d;
    logic [7:0] s;
    logic [15:0] a;
    exp_q.delete();
    i = 0;
    while (i < 11) begin
      b = sp[i];
      exp_q.push_back(b);
      if (b == ess_pkg::INSTR_END)
        break;
      if (b[7]) begin
        i++;
      end else begin
        a = {sp[i+1], sp[i+2]};
        exp_q.push_back(sp[i+1]);
        exp_q.push_back(sp[i+2]);
        s = 8'h00;
        for (int k = 0; k <= b; k++) begin
          d = ee.rm_val(a + 16'(k));
          exp_q.push_back(d);
          s = s + d;
        end
        exp_q.push_back(8'h00 - s);
        i += 3;
      end
    end
  endfunction

  // Start a run, wait for done, compare every stored word
  task automatic run_check(input int n_words);
    logic [31:0] st;
    expand();
    ee.log_q.delete();
    bus(1'b1, ess_pkg::IDX_CTRL, 32'h0000_0002, st);
    bus(1'b1, ess_pkg::IDX_CTRL, 32'h0000_0001, st);
    bus(1'b0, ess_pkg::IDX_STATUS, 32'h0000_0000, st);
    check({31'h0000_0000, st[0]}, 32'h0000_0001);
    st = 32'h0000_0000;
    for (int n = 0; n < 4000 && st[1] !== 1'b1; n++)
      bus(1'b0, ess_pkg::IDX_STATUS, 32'h0000_0000, st);
    for (int n = 0; n < 50 && ee.log_q.size() < exp_q.size(); n++)
      @(posedge CLK);
    check(32'(ee.log_q.size()), 32'(n_words));
    for (int i = 0; i < exp_q.size(); i++)
      check(32'({ee.log_q[i].addr, ee.log_q[i].data}), 32'({12'(i), exp_q[i]}));
    bus(1'b0, ess_pkg::IDX_POINTER, 32'h0000_0000, st);
    check(st, 32'h0000_0000);
    bus(1'b0, ess_pkg::IDX_STATUS, 32'h0000_0000, st);
    check(st, 32'h0000_0002);
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic test_reset_values();
    logic [31:0] rd;
    for (int i = 0; i < 11; i++) begin
      bus(1'b0, ess_pkg::IDX_SP_FIRST + 12'(i), 32'h0000_0000, rd);
      check(rd, {24'h00_0000, sp[i]});
    end
    bus(1'b1, 12'hE35, 32'h0000_005A, rd);
    bus(1'b0, 12'hE35, 32'h0000_0000, rd);
    check(rd, 32'h0000_0000);
    $display("test_reset_values finished");
  endtask

  // Default list with a slow store side so the buffer fills
  task automatic test_default_run();
    SLOW <= 1'b1;
    run_check(314);
    $display("test_default_run finished");
  endtask

  // One-count copy across a low-byte carry, a pause byte, then end
  task automatic test_edited_list();
    logic [31:0] rd;
    logic [7:0]  v [5] = '{8'h01, 8'h12, 8'hFF, 8'h81, 8'hFF};
    SLOW <= 1'b0;
    for (int i = 0; i < 5; i++) begin
      bus(1'b1, ess_pkg::IDX_SP_FIRST + 12'(i), {24'h00_0000, v[i]}, rd);
      sp[i] = v[i];
    end
    // list closed by an end byte
    run_check(8);
    $display("test_edited_list finished");
  endtask

  initial begin
    RST_N     = 1'b0;
    HSEL      = 1'b0;
    HADDR     = 32'h0000_0000;
    HTRANS    = 2'h0;
    HWRITE    = 1'b0;
    HSIZE     = 3'h2;
    HWDATA    = 32'h0000_0000;
    SLOW      = 1'b0;
    err_total = 0;
    tests_run = 0;
    cyc_r     = 0;
    repeat (8) @(posedge CLK);
    RST_N <= 1'b1;
    repeat (2) @(posedge CLK);
    test_reset_values();
    test_default_run();
    test_edited_list();
    final_report();
  end
endmodule // tb
